// ==== bench/test_ptp_timer.sv ====
// self-checking bench for the periodic 10-bit timer
`timescale 1ns/1ps
`default_nettype none
module test_ptp_timer;
	import ptp_pkg::*;
	// bench side of the ports
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_output_pin;
	logic        timer_output_pin_oe;
	logic        timer_event;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        err;

	ptp_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe),
		.timer_event(timer_event));

	// 125 MHz clock
	always #4 pclk = ~pclk;

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd  = prdata;
		err = pslverr;
		if (pready !== 1'b1) chk("pready", 32'h0000_0001, 32'h0000_0000);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(what, exp, rd);
	endtask

	task automatic rd_cnt(output logic [9:0] c);
		apb(1'b0, ADDR_CNT_LO, 8'h00);
		c[7:0] = rd[7:0];
		apb(1'b0, ADDR_CNT_HI, 8'h00);
		c[9:8] = rd[1:0];
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// stop, load control and compare values, clear flags, start at pclk rate
	task automatic cfg(input logic [7:0] c1, input logic [9:0] per, input logic [9:0] duty);
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL1, c1);
		wr(ADDR_DUTY_LO, duty[7:0]);
		wr(ADDR_DUTY_HI, {6'h00, duty[9:8]});
		wr(ADDR_PER_LO, per[7:0]);
		wr(ADDR_PER_HI, {6'h00, per[9:8]});
		wr(ADDR_STATUS, 8'h03);
		wr(ADDR_CTRL0, 8'h18);
	endtask

	task automatic test_regs();
		logic [11:0] tab [9] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_DUTY_LO,
			ADDR_DUTY_HI, ADDR_PER_LO, ADDR_PER_HI, ADDR_STATUS};
		foreach (tab[i]) rdc("reset value", tab[i], 32'h0000_0000);
		wr(ADDR_DUTY_LO, 8'hab);
		wr(ADDR_DUTY_HI, 8'hff);
		rdc("duty low", ADDR_DUTY_LO, 32'h0000_00ab);
		rdc("duty high", ADDR_DUTY_HI, 32'h0000_0003);
		wr(ADDR_PER_LO, 8'h5a);
		wr(ADDR_PER_HI, 8'hfe);
		rdc("period low", ADDR_PER_LO, 32'h0000_005a);
		rdc("period high", ADDR_PER_HI, 32'h0000_0002);
		wr(ADDR_CNT_LO, 8'h55);
		wr(ADDR_CNT_HI, 8'hff);
		rdc("counter low", ADDR_CNT_LO, 32'h0000_0000);
		rdc("counter high", ADDR_CNT_HI, 32'h0000_0000);
		apb(1'b0, 12'h040, 8'h00);
		chk("unmapped error", 32'h0000_0001, {31'h0, err});
	endtask

	task automatic test_cmp();
		logic [9:0] c;
		int n;
		cfg(8'h20, 10'd0, 10'd200);
		wait_clk(3);
		chk("pin oe", 32'h0000_0001, {31'h0, timer_output_pin_oe});
		chk("pin initial", 32'h0000_0000, {31'h0, timer_output_pin});
		wait_clk(250);
		chk("pin on duty match", 32'h0000_0001, {31'h0, timer_output_pin});
		rdc("duty flag only", ADDR_STATUS, 32'h0000_0001);
		wr(ADDR_CTRL0, 8'h10);
		wr(ADDR_CTRL0, 8'h18);
		wait_clk(2);
		chk("pin re-initialised", 32'h0000_0000, {31'h0, timer_output_pin});
		// period below duty: still no period flag
		cfg(8'h01, 10'd2, 10'd6);
		wait_clk(60);
		rdc("flags on duty clear", ADDR_STATUS, 32'h0000_0001);
		chk("pin field none", 32'h0000_0000, {31'h0, timer_output_pin});
		rd_cnt(c);
		chk("count bound duty", 32'h0000_0001, {31'h0, c <= 10'd6});
		cfg(8'h00, 10'd6, 10'd3);
		wait_clk(60);
		rdc("flags on period clear", ADDR_STATUS, 32'h0000_0003);
		rd_cnt(c);
		chk("count bound period", 32'h0000_0001, {31'h0, c <= 10'd6});
		// one duty and one period event per six-cycle period
		n = 0;
		repeat (60) begin
			@(posedge pclk);
			n += (timer_event === 1'b1);
		end
		chk("event pulses", 32'h0000_0014, n);
	endtask

	task automatic test_tmr();
		logic [9:0] a;
		logic [9:0] b;
		cfg(8'hc0, 10'd0, 10'd0);
		wait_clk(1100);
		chk("pin released", 32'h0000_0000, {31'h0, timer_output_pin_oe});
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk("zero duty flag", 32'h0000_0000, rd & 32'h0000_0001);
		wr(ADDR_CTRL0, 8'h98);
		rd_cnt(a);
		wait_clk(20);
		rd_cnt(b);
		chk("paused count", {22'h0, a}, {22'h0, b});
		wr(ADDR_CTRL0, 8'h18);
		wait_clk(20);
		rd_cnt(b);
		chk("resumed count", 32'h0000_0001, {31'h0, b > a});
		wr(ADDR_CTRL0, 8'h10);
		rd_cnt(a);
		wait_clk(20);
		rd_cnt(b);
		chk("disabled count", {22'h0, a}, {22'h0, b});
		wr(ADDR_CTRL0, 8'h18);
		rd_cnt(b);
		chk("restart from zero", 32'h0000_0001, {31'h0, b < 10'd10});
		// divide by four: 46 pclk between samples is 11 or 12 ticks
		wr(ADDR_CTRL0, 8'h08);
		rd_cnt(a);
		wait_clk(40);
		rd_cnt(b);
		b = b - a;
		chk("quarter rate", 32'h0000_0001, {31'h0, b >= 10'd10 && b <= 10'd13});
	endtask

	// counts high pin cycles over whole pwm periods
	task automatic pwm_run(input string what, input logic [7:0] c1, input logic [9:0] per,
		input logic [9:0] duty, input int n, input int exp);
		int hi;
		hi = 0;
		cfg(c1, per, duty);
		wait_clk(30);
		repeat (n) begin
			@(posedge pclk);
			hi += (timer_output_pin === 1'b1);
		end
		chk(what, exp, hi);
	endtask

	task automatic test_pwm();
		pwm_run("pwm duty", 8'ha8, 10'd8, 10'd2, 80, 20);
		pwm_run("pwm clear-select", 8'ha9, 10'd8, 10'd2, 80, 20);
		pwm_run("pwm full duty", 8'ha8, 10'd8, 10'd8, 80, 80);
		pwm_run("pwm inverted", 8'hac, 10'd8, 10'd2, 80, 60);
		pwm_run("pwm active low", 8'ha0, 10'd8, 10'd2, 80, 60);
		pwm_run("pwm forced active", 8'h98, 10'd8, 10'd2, 80, 80);
		pwm_run("pwm forced idle", 8'h88, 10'd8, 10'd2, 80, 0);
		rdc("pwm flags", ADDR_STATUS, 32'h0000_0003);
		pwm_run("pwm period 1024", 8'ha8, 10'd0, 10'd256, 1024, 256);
	endtask

	task automatic test_pulse();
		cfg(8'hb8, 10'd0, 10'd20);
		wait_clk(2);
		chk("pulse leading", 32'h0000_0001, {31'h0, timer_output_pin});
		wait_clk(40);
		chk("pulse trailing", 32'h0000_0000, {31'h0, timer_output_pin});
		rdc("enable cleared", ADDR_CTRL0, 32'h0000_0010);
		rdc("pulse flag", ADDR_STATUS, 32'h0000_0001);
		wr(ADDR_CTRL0, 8'h18);
		wait_clk(2);
		chk("pulse retrigger", 32'h0000_0001, {31'h0, timer_output_pin});
	endtask

	// reset for four cycles, then the scenarios in turn
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'hf;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_cmp();
		test_tmr();
		test_pwm();
		test_pulse();
		finish_test();
	end
endmodule // test_ptp_timer
`default_nettype wire

// ==== hw/ptp_pkg.sv ====
// package of constants for the periodic timer with pwm
package ptp_pkg;
	localparam int CNT_W = 10;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL0    = 12'h000;
	localparam logic [11:0] ADDR_CTRL1    = 12'h004;
	localparam logic [11:0] ADDR_CNT_LO   = 12'h008;
	localparam logic [11:0] ADDR_CNT_HI   = 12'h00c;
	localparam logic [11:0] ADDR_DUTY_LO  = 12'h010;
	localparam logic [11:0] ADDR_DUTY_HI  = 12'h014;
	localparam logic [11:0] ADDR_PER_LO   = 12'h018;
	localparam logic [11:0] ADDR_PER_HI   = 12'h01c;
	localparam logic [11:0] ADDR_STATUS   = 12'h020;
	// control 0 fields
	localparam int C0_PAUSE  = 7;
	localparam int C0_CKS_HI = 6;
	localparam int C0_CKS_LO = 4;
	localparam int C0_ENABLE = 3;
	// control 1 fields
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_PIN_HI  = 5;
	localparam int C1_PIN_LO  = 4;
	localparam int C1_OCTL    = 3;
	localparam int C1_POL     = 2;
	localparam int C1_CCLR    = 0;
	// status fields, write one to clear
	localparam int ST_DUTY = 0;
	localparam int ST_PER  = 1;
	// reset values and top count
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [9:0] VAL_RST  = 10'h000;
	localparam logic [9:0] CNT_MAX  = 10'h3ff;
	// mode and pin codes
	localparam logic [1:0] MODE_CMP = 2'b00;
	localparam logic [1:0] MODE_PWM = 2'b10;
	localparam logic [1:0] MODE_TMR = 2'b11;
	localparam logic [1:0] PIN_NONE = 2'b00;
	localparam logic [1:0] PIN_LOW  = 2'b01;
	localparam logic [1:0] PIN_HIGH = 2'b10;
	localparam logic [1:0] PIN_TOG  = 2'b11;
	// clock select codes
	localparam logic [2:0] CKS_SYS4  = 3'b000;
	localparam logic [2:0] CKS_SYS   = 3'b001;
	localparam logic [2:0] CKS_H16   = 3'b010;
	localparam logic [2:0] CKS_H64   = 3'b011;
	localparam logic [2:0] CKS_SUB0  = 3'b100;
	localparam logic [2:0] CKS_SUB1  = 3'b101;
	localparam int DIV_SYS4 = 4;
	localparam int DIV_H16  = 16;
	localparam int DIV_H64  = 64;
	localparam int DIV_SUB  = 256;
	localparam int DIV_W    = 8;
	typedef enum logic [1:0] {PTP_CMP, PTP_PWM, PTP_PULSE, PTP_IDLE} ptp_mode_t;
endpackage : ptp_pkg

// ==== hw/ptp_timer.sv ====
// periodic 10-bit timer with compare, pwm and single pulse, apb slave
// Notes on behaviour
// - counter read as low and high bytes
// - duty compare value, rw byte pair
// - period compare value, rw byte pair
// - mode field and pin field choose mode
// - clear-select low: clear on period match
// - clear-select high: clear on duty match
// - zero duty: overflow at 3ff, no flag
// - compare mode pin changes on duty match
// - enable rising edge loads initial pin level
// - timer mode counts, pin left undriven
// - pwm ignores clear-select, period clears counter
// - pwm period equals period value, zero=1024
// - duty at or above period gives 100%
// - pwm sets both match flags
// - pwm level, polarity, pin forcing
// - pulse starts on enable rising edge
// - duty match ends pulse, clears enable
// - pulse counter resets only on enable rise
// - enable rise zeroes counter, fall holds it
// - pause freezes counter, resumes later
// - clock select picks counter tick rate
`timescale 1ns/1ps
`default_nettype none
module ptp_timer #(
	parameter int CNT_WIDTH = ptp_pkg::CNT_W
) (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// timer pin and events
	output logic                      timer_output_pin,
	output logic                      timer_output_pin_oe,
	output logic                      timer_event
);
	import ptp_pkg::*;

	// software state
	logic [7:0]           ctrl0;
	logic [7:0]           ctrl1;
	logic [CNT_WIDTH-1:0] duty_compare_value;
	logic [CNT_WIDTH-1:0] period_compare_value;
	logic [CNT_WIDTH-1:0] count;
	logic                 duty_match_flag;
	logic                 period_match_flag;
	logic                 enable_d;
	logic                 pin_q;
	logic [DIV_W-1:0]     div_cnt;

	// field decode
	wire       timer_enable_bit   = ctrl0[C0_ENABLE];
	wire       counter_pause_bit  = ctrl0[C0_PAUSE];
	wire [2:0] counter_clock_select = ctrl0[C0_CKS_HI:C0_CKS_LO];
	wire [1:0] mode_select_field  = ctrl1[C1_MODE_HI:C1_MODE_LO];
	wire [1:0] pin_function_field = ctrl1[C1_PIN_HI:C1_PIN_LO];
	wire       output_control_bit = ctrl1[C1_OCTL];
	wire       output_polarity_bit = ctrl1[C1_POL];
	wire       clear_select_bit   = ctrl1[C1_CCLR];

	// mode select
	ptp_mode_t mode;
	always_comb begin
		case (mode_select_field)
			MODE_CMP: mode = PTP_CMP;
			MODE_TMR: mode = PTP_CMP;
			MODE_PWM: mode = (pin_function_field == PIN_TOG) ? PTP_PULSE : PTP_PWM;
			default:  mode = PTP_IDLE;
		endcase
	end
	wire is_tmr = (mode_select_field == MODE_TMR);

	// apb decode, one wait-free access phase
	wire acc     = psel && penable;
	wire wr      = acc && pwrite && pstrb[0];
	wire wr_c0   = wr && (paddr == ADDR_CTRL0);
	wire wr_c1   = wr && (paddr == ADDR_CTRL1);
	wire wr_dl   = wr && (paddr == ADDR_DUTY_LO);
	wire wr_dh   = wr && (paddr == ADDR_DUTY_HI);
	wire wr_pl   = wr && (paddr == ADDR_PER_LO);
	wire wr_ph   = wr && (paddr == ADDR_PER_HI);
	wire wr_st   = wr && (paddr == ADDR_STATUS);
	wire mapped  = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) || (paddr == ADDR_CNT_LO) ||
	               (paddr == ADDR_CNT_HI) || (paddr == ADDR_DUTY_LO) || (paddr == ADDR_DUTY_HI) ||
	               (paddr == ADDR_PER_LO) || (paddr == ADDR_PER_HI) || (paddr == ADDR_STATUS);

	// read mux, unused bits read zero except control 1 bit 1, which reads back as written
	logic [7:0] rd_byte;
	always_comb begin
		case (paddr)
			ADDR_CTRL0:   rd_byte = {ctrl0[7:3], 3'b000};
			ADDR_CTRL1:   rd_byte = ctrl1;
			ADDR_CNT_LO:  rd_byte = count[7:0];
			ADDR_CNT_HI:  rd_byte = {6'b00_0000, count[9:8]};
			ADDR_DUTY_LO: rd_byte = duty_compare_value[7:0];
			ADDR_DUTY_HI: rd_byte = {6'b00_0000, duty_compare_value[9:8]};
			ADDR_PER_LO:  rd_byte = period_compare_value[7:0];
			ADDR_PER_HI:  rd_byte = {6'b00_0000, period_compare_value[9:8]};
			ADDR_STATUS:  rd_byte = {6'b00_0000, period_match_flag, duty_match_flag};
			default:      rd_byte = 8'h00;
		endcase
	end

	// tick divider, one-cycle enables from pclk
	wire tick_4   = (div_cnt[1:0] == 2'(DIV_SYS4 - 1));
	wire tick_16  = (div_cnt[3:0] == 4'(DIV_H16 - 1));
	wire tick_64  = (div_cnt[5:0] == 6'(DIV_H64 - 1));
	wire tick_sub = (div_cnt == DIV_W'(DIV_SUB - 1));
	logic tick;
	always_comb begin
		case (counter_clock_select)
			CKS_SYS4: tick = tick_4;
			CKS_SYS:  tick = 1'b1;
			CKS_H16:  tick = tick_16;
			CKS_H64:  tick = tick_64;
			CKS_SUB0: tick = tick_sub;
			CKS_SUB1: tick = tick_sub;
			default:  tick = 1'b0; // reserved codes never tick
		endcase
	end

	// comparators, equality only
	wire duty_zero = (duty_compare_value == VAL_RST);
	wire per_zero  = (period_compare_value == VAL_RST);
	// counting waits one cycle after an enable rise, so a stale count cannot raise a hit
	wire running   = timer_enable_bit && enable_d && !counter_pause_bit && tick;
	wire en_rise   = timer_enable_bit && !enable_d;
	wire [CNT_WIDTH-1:0] cnt_inc = count + CNT_WIDTH'(1);
	wire duty_hit  = running && !duty_zero && (cnt_inc == duty_compare_value);
	wire per_hit   = running && !per_zero && (cnt_inc == period_compare_value);
	wire ovf_hit   = running && (count == CNT_MAX);

	// clear and flag causes by mode
	wire cmp_mode  = (mode == PTP_CMP);
	wire clr_cmp   = cmp_mode && (clear_select_bit ? duty_hit : (per_hit || (per_zero && ovf_hit)));
	wire clr_pwm   = (mode == PTP_PWM) && (per_hit || (per_zero && ovf_hit));
	wire set_duty  = duty_hit && (mode != PTP_IDLE);
	wire set_per   = per_hit && (cmp_mode ? !clear_select_bit : (mode == PTP_PWM));
	wire pulse_end = (mode == PTP_PULSE) && duty_hit;

	// counter next value; pulse mode never wraps on period
	logic [CNT_WIDTH-1:0] next_count;
	always_comb begin
		if (en_rise)
			next_count = VAL_RST;
		else if (clr_cmp || clr_pwm)
			next_count = VAL_RST;
		else if (running)
			next_count = cnt_inc;
		else
			next_count = count;
	end

	// pwm level: active while count below duty, 100% when duty >= period
	wire [CNT_WIDTH:0] per_ext = per_zero ? {1'b1, VAL_RST} : {1'b0, period_compare_value};
	wire pwm_active = ({1'b0, duty_compare_value} >= per_ext) || (next_count < duty_compare_value);
	logic pwm_level;
	always_comb begin
		case (pin_function_field)
			PIN_NONE: pwm_level = !output_control_bit; // inactive
			PIN_LOW:  pwm_level = output_control_bit;  // active
			default:  pwm_level = pwm_active ? output_control_bit : !output_control_bit;
		endcase
	end

	// compare-mode pin action
	logic cmp_level;
	always_comb begin
		case (pin_function_field)
			PIN_LOW:  cmp_level = 1'b0;
			PIN_HIGH: cmp_level = 1'b1;
			PIN_TOG:  cmp_level = !pin_q;
			default:  cmp_level = pin_q;
		endcase
	end

	// pin next value
	logic next_pin;
	always_comb begin
		if (mode == PTP_PWM)
			next_pin = pwm_level;
		else if (mode == PTP_PULSE)
			next_pin = (timer_enable_bit && !pulse_end) ? output_control_bit : !output_control_bit;
		else if (en_rise)
			next_pin = output_control_bit;
		else if (set_duty && cmp_mode)
			next_pin = cmp_level;
		else
			next_pin = pin_q;
	end

	// control registers; a duty match in pulse mode drops the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0 <= CTRL_RST;
			ctrl1 <= CTRL_RST;
		end else begin
			if (wr_c0)
				ctrl0 <= pwdata[7:0];
			else if (pulse_end)
				ctrl0[C0_ENABLE] <= 1'b0;
			if (wr_c1)
				ctrl1 <= pwdata[7:0];
		end
	end

	// compare values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_compare_value   <= VAL_RST;
			period_compare_value <= VAL_RST;
		end else begin
			if (wr_dl) duty_compare_value[7:0] <= pwdata[7:0];
			if (wr_dh) duty_compare_value[9:8] <= pwdata[1:0];
			if (wr_pl) period_compare_value[7:0] <= pwdata[7:0];
			if (wr_ph) period_compare_value[9:8] <= pwdata[1:0];
		end
	end

	// flags: write one clears, a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_match_flag   <= 1'b0;
			period_match_flag <= 1'b0;
		end else begin
			duty_match_flag   <= set_duty || (duty_match_flag && !(wr_st && pwdata[ST_DUTY]));
			period_match_flag <= set_per || (period_match_flag && !(wr_st && pwdata[ST_PER]));
		end
	end

	// counter, divider, edge memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count    <= VAL_RST;
			div_cnt  <= '0;
			enable_d <= 1'b0;
		end else begin
			count    <= next_count;
			div_cnt  <= div_cnt + DIV_W'(1);
			enable_d <= timer_enable_bit;
		end
	end

	// pin: polarity applies in every mode; timer mode releases the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q               <= 1'b0;
			timer_output_pin    <= 1'b0;
			timer_output_pin_oe <= 1'b0;
			timer_event         <= 1'b0;
		end else begin
			pin_q               <= next_pin;
			timer_output_pin    <= next_pin ^ output_polarity_bit;
			timer_output_pin_oe <= !is_tmr && (mode != PTP_IDLE);
			timer_event         <= set_duty || set_per;
		end
	end

	// apb answer, zero wait states, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// enable rise zeroes the counter on the next edge
	a_rise_zero: assert property (@(posedge pclk) disable iff (!presetn)
		en_rise |=> (count == VAL_RST)) else $error("counter not zeroed on enable rise");

	// a stopped timer keeps its residual count
	a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_enable_bit |=> $stable(count)) else $error("counter moved while disabled");

	// pause freezes the count
	a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(counter_pause_bit && !en_rise) |=> $stable(count)) else $error("counter moved while paused");

	// no compare hit can sneak through a pause
	a_pause_no_hit: assert property (@(posedge pclk) disable iff (!presetn)
		counter_pause_bit |-> (!duty_hit && !per_hit)) else $error("compare hit while paused");

	// divide-by-four ticks are never back to back
	a_quarter_tick: assert property (@(posedge pclk) disable iff (!presetn)
		((counter_clock_select == CKS_SYS4) && running && !wr_c0)
		|=> !running) else $error("quarter rate ticked twice");

	// zero duty never raises the duty flag
	a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
		(duty_zero && !duty_match_flag && !wr_dl && !wr_dh)
		|=> !duty_match_flag) else $error("flag on zero duty");

	// the top count always wraps to zero
	a_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(running && (count == CNT_MAX)) |=> (count == VAL_RST)) else $error("no wrap at top count");

	// clear-select low: period match clears the counter
	a_cmp_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_mode && !clear_select_bit && per_hit && !en_rise)
		|=> (count == VAL_RST)) else $error("no clear on period");

	// clear-select low: period match raises its flag
	a_per_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_mode && !clear_select_bit && per_hit) |=> period_match_flag) else $error("period flag missing");

	// clear-select high: duty match clears the counter
	a_duty_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_mode && clear_select_bit && duty_hit) |=> (count == VAL_RST)) else $error("no clear on duty");

	// clear-select high: never a period flag
	a_cclr_no_per: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_mode && clear_select_bit) |-> !set_per) else $error("period flag with clear-select high");

	// compare pin holds unless a duty flag or an enable rise moves it
	a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp_mode && !en_rise && !set_duty) |=> $stable(pin_q)) else $error("compare pin moved without match");

	// enable rise loads the initial pin level
	a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
		(en_rise && cmp_mode) |=> (pin_q == $past(output_control_bit))) else $error("initial level wrong");

	// timer mode lets go of the pin
	a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
		is_tmr |=> !timer_output_pin_oe) else $error("pin driven in timer mode");

	// pwm period match wraps the counter
	a_pwm_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == PTP_PWM) && per_hit) |=> (count == VAL_RST)) else $error("pwm period not cleared");

	// pwm duty match never clears, whatever clear-select says
	a_pwm_cclr: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == PTP_PWM) && duty_hit && !per_hit)
		|=> (count != VAL_RST)) else $error("pwm cleared on duty");

	// pwm duty match raises the duty flag
	a_pwm_duty_flag: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == PTP_PWM) && duty_hit) |=> duty_match_flag) else $error("pwm duty flag missing");

	// duty at or above period holds the active level
	a_pwm_full: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == PTP_PWM) && pin_function_field == PIN_HIGH && ({1'b0, duty_compare_value} >= per_ext))
		|=> (pin_q == $past(output_control_bit))) else $error("pwm not at full duty");

	// pulse leading edge follows the enable rise
	a_pulse_lead: assert property (@(posedge pclk) disable iff (!presetn)
		((mode == PTP_PULSE) && en_rise)
		|=> (pin_q == $past(output_control_bit))) else $error("no pulse leading edge");

	// pulse end: enable drops, then the pin leaves the active level
	sequence s_pulse_hit;
		(mode == PTP_PULSE) && duty_hit && !wr_c0;
	endsequence
	a_pulse_stop: assert property (@(posedge pclk) disable iff (!presetn)
		s_pulse_hit |=> !timer_enable_bit ##1 ($past(wr_c1, 2) || pin_q != $past(output_control_bit)))
		else $error("pulse not ended");
endmodule : ptp_timer
`default_nettype wire
